// [design/bhs_regs.svh]
`ifndef BHS_REGS_SVH
`define BHS_REGS_SVH

// ----------------------------------------
// Register map
// ----------------------------------------
`define BHS_OFS_CTRL 12'h000
`define BHS_OFS_STATUS 12'h004
`define BHS_OFS_PADDR 12'h008
`define BHS_CTRL_EN_BIT 0
`define BHS_CTRL_RST 1'b1

// ----------------------------------------
// Service codes and related constants
// ----------------------------------------
`define BHS_SVC_RESET 8'h01
`define BHS_SVC_STATE 8'h02
`define BHS_SVC_SETBUSY 8'h03
`define BHS_SVC_QUITBUSY 8'h04
`define BHS_SVC_BUSMON 8'h05
`define BHS_SVC_SETADDR 8'hF1
`define BHS_SVC_SETREP 8'hF2
`define BHS_SVC_START 8'h80
`define BHS_END_MIN 6'h07
`define BHS_IND_RESET 8'h03
`define BHS_CON_LOW 7'h0B
`define BHS_ACK_MASK 8'hCC

`endif

// [design/bhs_pkg.sv]
package bhs_pkg;

	typedef enum logic [2:0] {
		BHS_P_IDLE = 3'b001,
		BHS_P_DATA = 3'b010,
		BHS_P_SKIP = 3'b100
	} bhs_pstate_t;

	typedef enum logic [1:0] {
		BHS_D_POWERUP = 2'b00,
		BHS_D_SYNC = 2'b01,
		BHS_D_STOP = 2'b10,
		BHS_D_NORMAL = 2'b11
	} bhs_dstate_t;

	typedef enum logic [1:0] {
		BHS_RX_DATA = 2'b00,
		BHS_RX_CTRL = 2'b01,
		BHS_RX_ACK = 2'b10
	} bhs_rxkind_t;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} bhs_apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} bhs_apb_rsp_t;

	typedef struct packed {
		bhs_pstate_t pst;
		logic [7:0] cmd;
		logic [1:0] cnt;
		logic sc, re, te, pe;
		logic busy, aa, ap, crc, mrk, mon;
		logic [15:0] paddr;
		logic [63:0][7:0] buff;
		logic [63:0] bufv;
		logic [7:0] txrd;
		logic [6:0] tx_len;
		logic tx_act, tx_start;
		logic out_v;
		logic [7:0] out_d;
		logic pend_rst, pend_st, pend_cfg, pend_con, con_ok, pend_fe;
		logic [2:0] fe_bits;
		bhs_dstate_t dst_q;
		logic ctrl_en;
		logic [31:0] rd;
		logic ack_busy, ack_req;
		logic [2:0] ack_bits;
		logic dig_rst;
	} bhs_state_t;

endpackage

// [design/bhs_interp.sv]
`timescale 1ns/1ps
`include "bhs_regs.svh"

module bhs_interp import bhs_pkg::*; (
	input wire logic SYS_CLK_I,
	input wire logic SYS_RST_I,
	input wire bhs_apb_req_t APB_REQ_I,
	output bhs_apb_rsp_t APB_RSP_O,
	input wire logic HOST_RX_VALID_I,
	input wire logic [7:0] HOST_RX_DATA_I,
	output logic HOST_RX_READY_O,
	output logic HOST_TX_VALID_O,
	output logic [7:0] HOST_TX_DATA_O,
	input wire logic HOST_TX_READY_I,
	input wire logic BUS_RX_VALID_I,
	input wire bhs_rxkind_t BUS_RX_KIND_I,
	input wire logic [7:0] BUS_RX_DATA_I,
	output logic BUS_RX_READY_O,
	output logic BUS_TX_START_O,
	output logic [6:0] BUS_TX_LEN_O,
	input wire logic [5:0] BUS_TX_RADDR_I,
	output logic [7:0] BUS_TX_RDATA_O,
	input wire logic BUS_TX_DONE_I,
	input wire logic BUS_TX_OK_I,
	output logic TX_ACTIVE_O,
	input wire logic BUS_ADDR_HIT_I,
	output logic BUS_ACK_BUSY_O,
	output logic ACK_REQ_O,
	output logic [2:0] ACK_BITS_O,
	input wire logic ERR_SC_I,
	input wire logic ERR_RE_I,
	input wire logic ERR_TE_I,
	input wire logic THERM_WARN_I,
	input wire logic FRAME_ERR_I,
	input wire logic [2:0] FRAME_ERR_BITS_I,
	input wire bhs_dstate_t DIG_STATE_I,
	output logic DIG_RESET_O,
	output logic MON_MODE_O,
	output logic BUSY_MODE_O,
	output logic AUTO_ACK_O,
	output logic [15:0] PHYS_ADDR_O
);

	localparam bhs_state_t RST_S = '{
		pst: BHS_P_IDLE,
		dst_q: BHS_D_POWERUP,
		ctrl_en: `BHS_CTRL_RST,
		default: '0
	};

	bhs_state_t s_r;
	bhs_state_t s_nxt;
	logic normal;
	logic host_take;
	logic bus_take;
	logic [7:0] b;
	logic [63:0] len_mask;
	logic [31:0] rd_val;
	logic addr_ok;
	logic apb_wr;

	// ----------------------------------------
	// Handshakes
	// ----------------------------------------
	assign normal = (DIG_STATE_I == BHS_D_NORMAL);
	assign HOST_RX_READY_O = s_r.ctrl_en & ~s_r.pend_st & ~s_r.pend_cfg & ~s_r.pend_con;
	assign BUS_RX_READY_O = ~s_r.out_v;
	assign host_take = HOST_RX_VALID_I & HOST_RX_READY_O;
	assign bus_take = BUS_RX_VALID_I & BUS_RX_READY_O;
	assign b = HOST_RX_DATA_I;
	assign len_mask = (64'h1 << s_r.cmd[5:0]) - 64'h1;

	// ----------------------------------------
	// APB decode
	// ----------------------------------------
	always_comb begin
		addr_ok = 1'b1;
		rd_val = 32'h0000_0000;
		case (APB_REQ_I.paddr)
			`BHS_OFS_CTRL: rd_val = {31'h0, s_r.ctrl_en};
			`BHS_OFS_STATUS: rd_val = {20'h0, s_r.tx_act, s_r.mon, s_r.busy, s_r.aa,
				s_r.ap, s_r.crc, s_r.mrk, s_r.sc, s_r.re, s_r.te, s_r.pe, THERM_WARN_I};
			`BHS_OFS_PADDR: rd_val = {16'h0, s_r.paddr};
			default: addr_ok = 1'b0;
		endcase
	end

	assign apb_wr = APB_REQ_I.psel & APB_REQ_I.penable & APB_REQ_I.pwrite;
	assign APB_RSP_O.prdata = s_r.rd;
	assign APB_RSP_O.pready = 1'b1;
	assign APB_RSP_O.pslverr = APB_REQ_I.psel & APB_REQ_I.penable & ~addr_ok;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		s_nxt = s_r;
		s_nxt.tx_start = 1'b0;
		s_nxt.ack_busy = 1'b0;
		s_nxt.ack_req = 1'b0;
		s_nxt.dig_rst = 1'b0;
		s_nxt.dst_q = DIG_STATE_I;
		s_nxt.txrd = s_r.buff[BUS_TX_RADDR_I];

		if (APB_REQ_I.psel & ~APB_REQ_I.penable) begin
			s_nxt.rd = rd_val;
		end
		if (apb_wr && APB_REQ_I.paddr == `BHS_OFS_CTRL) begin
			s_nxt.ctrl_en = APB_REQ_I.pwdata[`BHS_CTRL_EN_BIT];
		end

		// Output byte slot
		if (s_r.out_v & HOST_TX_READY_I) begin
			s_nxt.out_v = 1'b0;
		end
		if (!s_r.out_v) begin
			if (bus_take) begin
				case (BUS_RX_KIND_I)
					BHS_RX_CTRL: begin
						s_nxt.out_v = 1'b1;
						s_nxt.out_d = {BUS_RX_DATA_I[7], 1'b0, BUS_RX_DATA_I[5], 1'b1,
							BUS_RX_DATA_I[3:2], 2'b00};
					end
					BHS_RX_ACK: begin
						s_nxt.out_v = s_r.mon;
						s_nxt.out_d = BUS_RX_DATA_I & `BHS_ACK_MASK;
					end
					default: begin
						s_nxt.out_v = 1'b1;
						s_nxt.out_d = BUS_RX_DATA_I;
					end
				endcase
			end else if (s_r.pend_rst) begin
				s_nxt.pend_rst = 1'b0;
				s_nxt.out_v = 1'b1;
				s_nxt.out_d = `BHS_IND_RESET;
			end else if (s_r.pend_con) begin
				s_nxt.pend_con = 1'b0;
				s_nxt.out_v = 1'b1;
				s_nxt.out_d = {s_r.con_ok, `BHS_CON_LOW};
			end else if (s_r.pend_fe) begin
				s_nxt.pend_fe = 1'b0;
				s_nxt.out_v = 1'b1;
				s_nxt.out_d = {s_r.fe_bits, 1'b1, 1'b0, 3'b011};
			end else if (s_r.pend_st) begin
				s_nxt.pend_st = 1'b0;
				s_nxt.out_v = 1'b1;
				s_nxt.out_d = {s_r.sc, s_r.re, s_r.te, s_r.pe, THERM_WARN_I, 3'b111};
				s_nxt.sc = 1'b0;
				s_nxt.re = 1'b0;
				s_nxt.te = 1'b0;
				s_nxt.pe = 1'b0;
			end else if (s_r.pend_cfg) begin
				s_nxt.pend_cfg = 1'b0;
				s_nxt.out_v = 1'b1;
				s_nxt.out_d = {2'b00, s_r.aa, s_r.ap, s_r.crc, s_r.mrk, 2'b01};
			end
		end

		// Host command interpreter
		if (host_take) begin
			case (s_r.pst)
				BHS_P_IDLE: begin
					if (b == `BHS_SVC_RESET) begin
						s_nxt = RST_S;
						s_nxt.ctrl_en = s_r.ctrl_en;
						s_nxt.rd = s_nxt.rd | s_r.rd;
						s_nxt.dig_rst = 1'b1;
					end else if (s_r.mon) begin
						s_nxt.pst = BHS_P_IDLE;
					end else if (b == `BHS_SVC_STATE) begin
						s_nxt.pend_st = 1'b1;
					end else if (b == `BHS_SVC_SETBUSY) begin
						s_nxt.busy = s_r.aa;
					end else if (b == `BHS_SVC_QUITBUSY) begin
						s_nxt.busy = 1'b0;
					end else if (b == `BHS_SVC_BUSMON) begin
						s_nxt.mon = 1'b1;
					end else if (b == `BHS_SVC_SETADDR) begin
						s_nxt.pst = BHS_P_DATA;
						s_nxt.cmd = b;
						s_nxt.cnt = 2'd0;
					end else if (b == `BHS_SVC_SETREP || b[7:4] == 4'hE) begin
						s_nxt.pst = BHS_P_SKIP;
						s_nxt.cnt = 2'd3;
					end else if (b[7:2] == 6'b001010) begin
						s_nxt.pst = BHS_P_SKIP;
						s_nxt.cnt = 2'd1;
					end else if (b[7:3] == 5'b00011) begin
						s_nxt.ap = b[2];
						s_nxt.crc = b[1];
						s_nxt.mrk = b[0];
						s_nxt.pend_cfg = 1'b1;
					end else if (b[7:3] == 5'b00010) begin
						if (normal) begin
							s_nxt.busy = 1'b0;
							s_nxt.ack_req = 1'b1;
							s_nxt.ack_bits = b[2:0];
						end else begin
							s_nxt.pe = 1'b1;
							s_nxt.pend_st = 1'b1;
						end
					end else if (b[7:6] == 2'b10 ||
						(b[7:6] == 2'b01 && b[5:0] >= `BHS_END_MIN)) begin
						if (normal) begin
							s_nxt.pst = BHS_P_DATA;
							s_nxt.cmd = b;
							if (b == `BHS_SVC_START) begin
								s_nxt.bufv = '0;
							end
						end else begin
							s_nxt.pe = 1'b1;
							s_nxt.pend_st = 1'b1;
						end
					end
				end
				BHS_P_DATA: begin
					s_nxt.pst = BHS_P_IDLE;
					if (s_r.cmd == `BHS_SVC_SETADDR) begin
						s_nxt.cnt = s_r.cnt + 2'd1;
						if (s_r.cnt == 2'd0) begin
							s_nxt.pst = BHS_P_DATA;
							s_nxt.paddr[15:8] = b;
						end else if (s_r.cnt == 2'd1) begin
							s_nxt.pst = BHS_P_DATA;
							s_nxt.paddr[7:0] = b;
						end else begin
							s_nxt.aa = 1'b1;
							s_nxt.pend_cfg = ~s_r.aa;
						end
					end else if (s_r.cmd[7:6] == 2'b10) begin
						s_nxt.buff[s_r.cmd[5:0]] = b;
						s_nxt.bufv[s_r.cmd[5:0]] = 1'b1;
					end else begin
						s_nxt.buff[s_r.cmd[5:0]] = b;
						s_nxt.bufv = '0;
						if ((s_r.bufv & len_mask) == len_mask) begin
							s_nxt.tx_start = 1'b1;
							s_nxt.tx_act = 1'b1;
							s_nxt.tx_len = {1'b0, s_r.cmd[5:0]} + 7'd1;
						end else begin
							s_nxt.pend_con = 1'b1;
							s_nxt.con_ok = 1'b0;
						end
					end
				end
				BHS_P_SKIP: begin
					s_nxt.cnt = s_r.cnt - 2'd1;
					if (s_r.cnt == 2'd1) begin
						s_nxt.pst = BHS_P_IDLE;
					end
				end
				default: begin
					s_nxt.pst = BHS_P_IDLE;
				end
			endcase
		end

		// Hardware events; a set wins over a same-cycle clear, except pend_rst, which a same-cycle reset service suppresses, and tx_act, which BUS_TX_DONE_I clears
		if (s_r.dst_q != BHS_D_NORMAL && normal && !s_nxt.dig_rst) begin
			s_nxt.pend_rst = 1'b1;
		end
		if (BUS_TX_DONE_I && s_r.tx_act) begin
			s_nxt.tx_act = 1'b0;
			s_nxt.pend_con = 1'b1;
			s_nxt.con_ok = BUS_TX_OK_I;
		end
		if (FRAME_ERR_I) begin
			s_nxt.pend_fe = 1'b1;
			s_nxt.fe_bits = FRAME_ERR_BITS_I;
		end
		if (ERR_SC_I) begin
			s_nxt.sc = 1'b1;
		end
		if (ERR_RE_I) begin
			s_nxt.re = 1'b1;
		end
		if (ERR_TE_I) begin
			s_nxt.te = 1'b1;
		end
		if (BUS_ADDR_HIT_I && s_r.busy && s_r.aa) begin
			s_nxt.ack_busy = 1'b1;
		end
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge SYS_CLK_I) begin
		if (SYS_RST_I) begin
			s_r <= RST_S;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign HOST_TX_VALID_O = s_r.out_v;
	assign HOST_TX_DATA_O = s_r.out_d;
	assign BUS_TX_START_O = s_r.tx_start;
	assign BUS_TX_LEN_O = s_r.tx_len;
	assign BUS_TX_RDATA_O = s_r.txrd;
	assign TX_ACTIVE_O = s_r.tx_act;
	assign BUS_ACK_BUSY_O = s_r.ack_busy;
	assign ACK_REQ_O = s_r.ack_req;
	assign ACK_BITS_O = s_r.ack_bits;
	assign DIG_RESET_O = s_r.dig_rst;
	assign MON_MODE_O = s_r.mon;
	assign BUSY_MODE_O = s_r.busy;
	assign AUTO_ACK_O = s_r.aa;
	assign PHYS_ADDR_O = s_r.paddr;

endmodule

// [tb/bhs_interp_monitor.sv]
`timescale 1ns/1ps
module bhs_interp_monitor import bhs_pkg::*; (
	input wire logic SYS_CLK_I,
	input wire logic SYS_RST_I,
	input wire logic HOST_RX_VALID_I,
	input wire logic [7:0] HOST_RX_DATA_I,
	input wire logic HOST_RX_READY_O,
	input wire logic HOST_TX_VALID_O,
	input wire logic [7:0] HOST_TX_DATA_O,
	input wire logic BUS_RX_VALID_I,
	input wire bhs_rxkind_t BUS_RX_KIND_I,
	input wire logic [7:0] BUS_RX_DATA_I,
	input wire logic BUS_RX_READY_O,
	input wire logic BUS_TX_START_O,
	input wire logic [6:0] BUS_TX_LEN_O,
	input wire logic TX_ACTIVE_O,
	input wire logic BUS_ADDR_HIT_I,
	input wire logic BUS_ACK_BUSY_O,
	input wire logic MON_MODE_O,
	input wire logic BUSY_MODE_O,
	input wire logic AUTO_ACK_O
);
	// ----------------
	// Port relations
	// ----------------
	default clocking @(posedge SYS_CLK_I); endclocking
	default disable iff (SYS_RST_I);
	logic bt;
	assign bt = BUS_RX_VALID_I && BUS_RX_READY_O;
	property p_fwd;
		bt && BUS_RX_KIND_I == BHS_RX_DATA |=> HOST_TX_VALID_O
			&& HOST_TX_DATA_O == $past(BUS_RX_DATA_I);
	endproperty
	a_fwd: assert property (p_fwd) else $error("bus data not forwarded");
	property p_ctl;
		bt && BUS_RX_KIND_I == BHS_RX_CTRL |=> HOST_TX_DATA_O
			== (($past(BUS_RX_DATA_I) & 8'hAC) | 8'h10);
	endproperty
	a_ctl: assert property (p_ctl) else $error("bad frame indication");
	property p_ack;
		bt && BUS_RX_KIND_I == BHS_RX_ACK && MON_MODE_O |=> HOST_TX_VALID_O
			&& HOST_TX_DATA_O == ($past(BUS_RX_DATA_I) & 8'hCC);
	endproperty
	a_ack: assert property (p_ack) else $error("bad ack byte");
	property p_bsy;
		BUS_ADDR_HIT_I && BUSY_MODE_O && AUTO_ACK_O |=> BUS_ACK_BUSY_O;
	endproperty
	a_bsy: assert property (p_bsy) else $error("no busy ack");
	property p_aa;
		BUSY_MODE_O |-> AUTO_ACK_O;
	endproperty
	a_aa: assert property (p_aa) else $error("busy without auto ack");
	property p_mon;
		MON_MODE_O && !(HOST_RX_VALID_I && HOST_RX_READY_O && HOST_RX_DATA_I == 8'h01)
			|=> MON_MODE_O;
	endproperty
	a_mon: assert property (p_mon) else $error("monitor mode left");
	property p_len;
		BUS_TX_START_O |-> BUS_TX_LEN_O inside {[7'h08:7'h40]};
	endproperty
	a_len: assert property (p_len) else $error("bad frame length");
	property p_go;
		BUS_TX_START_O |=> TX_ACTIVE_O;
	endproperty
	a_go: assert property (p_go) else $error("start without transmit");
	c_bsy: cover property (BUS_ACK_BUSY_O);
	c_go: cover property (BUS_TX_START_O);
	c_mon: cover property (bt && MON_MODE_O);
endmodule
bind bhs_interp bhs_interp_monitor mon_u (.*);

// [tb/bhs_host_model.sv]
`timescale 1ns/1ps
module bhs_host_model (
	input wire logic clk_i,
	input wire logic rst_i,
	output logic valid_o,
	output logic [7:0] data_o,
	input wire logic ready_i,
	input wire logic reply_valid_i,
	input wire logic [7:0] reply_data_i,
	output logic reply_ready_o,
	input wire logic slow_i
);
	logic [7:0] got_q[$];
	logic ph_r;
	int stuck;
	initial begin
		valid_o = 1'b0;
		data_o = 8'h5A;
		reply_ready_o = 1'b1;
		ph_r = 1'b0;
		stuck = 0;
	end
	// Replies taken every other cycle when slow
	always @(posedge clk_i) begin
		if (reply_valid_i && reply_ready_o && !rst_i)
			got_q.push_back(reply_data_i);
		ph_r <= ~ph_r;
		reply_ready_o <= !slow_i || ph_r;
	end
	// Whole command, control byte first
	task automatic send(input logic [7:0] bq[$]);
		int n;
		logic tk;
		valid_o <= 1'b1;
		foreach (bq[i]) begin
			data_o <= bq[i];
			n = 0;
			// Ready judged mid-cycle, as the taking edge sees it
			do begin
				@(negedge clk_i);
				tk = ready_i;
				@(posedge clk_i);
				n++;
			end while (!tk && n < 50);
			if (!tk)
				stuck++;
		end
		valid_o <= 1'b0;
		data_o <= ~bq[bq.size() - 1];
		@(posedge clk_i);
	endtask
endmodule

// [tb/test_bus_host_service_interpreter.sv]
`timescale 1ns/1ps
module test_bus_host_service_interpreter import bhs_pkg::*;;
	logic clk, rst, hv, hrx_rdy, tv, tr, brx_v, brx_rdy, tx_start, tx_act, done, ok, hit;
	logic ack_busy, err_sc, therm, mon, busy, aa, slow, rdy;
	logic [7:0] hd, td, brx_d, rdata;
	logic [6:0] tx_len;
	logic [5:0] raddr;
	logic [15:0] paddr;
	bhs_rxkind_t brx_k;
	bhs_dstate_t dig;
	bhs_apb_req_t req;
	bhs_apb_rsp_t rsp;
	int num_errors, check_count;
	always_comb rdy = rsp.pready;
	bhs_interp dut_u (.SYS_CLK_I(clk), .SYS_RST_I(rst), .APB_REQ_I(req), .APB_RSP_O(rsp),
		.HOST_RX_VALID_I(hv), .HOST_RX_DATA_I(hd), .HOST_RX_READY_O(hrx_rdy),
		.HOST_TX_VALID_O(tv), .HOST_TX_DATA_O(td), .HOST_TX_READY_I(tr),
		.BUS_RX_VALID_I(brx_v), .BUS_RX_KIND_I(brx_k), .BUS_RX_DATA_I(brx_d),
		.BUS_RX_READY_O(brx_rdy), .BUS_TX_START_O(tx_start), .BUS_TX_LEN_O(tx_len),
		.BUS_TX_RADDR_I(raddr), .BUS_TX_RDATA_O(rdata), .BUS_TX_DONE_I(done),
		.BUS_TX_OK_I(ok), .TX_ACTIVE_O(tx_act), .BUS_ADDR_HIT_I(hit),
		.BUS_ACK_BUSY_O(ack_busy), .ACK_REQ_O(), .ACK_BITS_O(), .ERR_SC_I(err_sc),
		.ERR_RE_I(1'b0), .ERR_TE_I(1'b0), .THERM_WARN_I(therm), .FRAME_ERR_I(1'b0),
		.FRAME_ERR_BITS_I(3'h0), .DIG_STATE_I(dig), .DIG_RESET_O(), .MON_MODE_O(mon),
		.BUSY_MODE_O(busy), .AUTO_ACK_O(aa), .PHYS_ADDR_O(paddr));
	bhs_host_model host_u (.clk_i(clk), .rst_i(rst), .valid_o(hv), .data_o(hd),
		.ready_i(hrx_rdy), .reply_valid_i(tv), .reply_data_i(td), .reply_ready_o(tr),
		.slow_i(slow));
	// ----------------
	// Shared tasks
	// ----------------
	task automatic summarize;
		num_errors += host_u.stuck;
		if (num_errors == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wait_on(ref logic s);
		int n;
		logic seen;
		n = 0;
		// Level judged mid-cycle, as the taking edge sees it
		do begin
			@(negedge clk);
			seen = (s === 1'b1);
			@(posedge clk);
			n++;
		end while (!seen && n < 50);
		if (!seen) begin
			num_errors++;
			summarize();
		end
	endtask
	task automatic expect_byte(input logic [7:0] x);
		for (int n = 0; n < 60 && host_u.got_q.size() == 0; n++) @(posedge clk);
		if (host_u.got_q.size() == 0) begin
			num_errors++;
			summarize();
		end
		chk({8'h0, host_u.got_q.pop_front()}, {8'h0, x});
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic e);
		req <= '{1'b1, 1'b0, w, a, d};
		@(posedge clk);
		req.penable <= 1'b1;
		wait_on(rdy);
		rd = rsp.prdata;
		e = rsp.pslverr;
		req <= '0;
		@(posedge clk);
	endtask
	task automatic bus_byte(input bhs_rxkind_t k, input logic [7:0] d);
		brx_v <= 1'b1;
		brx_k <= k;
		brx_d <= d;
		wait_on(brx_rdy);
		brx_v <= 1'b0;
		brx_d <= ~d;
		@(posedge clk);
	endtask
	// ----------------
	// Scenarios
	// ----------------
	task automatic s_apb;
		logic [31:0] rd;
		logic e;
		apb(1'b0, 12'h000, 32'h0, rd, e);
		chk(rd[15:0], 16'h1);
		apb(1'b0, 12'h00C, 32'h0, rd, e);
		chk(16'(e), 16'h1);
		apb(1'b1, 12'h000, 32'h0, rd, e);
		chk(16'(hrx_rdy), 16'h0);
		apb(1'b1, 12'h000, 32'h1, rd, e);
	endtask
	task automatic s_state;
		err_sc <= 1'b1;
		therm <= 1'b1;
		@(posedge clk);
		err_sc <= 1'b0;
		host_u.send({8'h02});
		expect_byte(8'h8F);
		therm <= 1'b0;
		host_u.send({8'h02});
		expect_byte(8'h07);
		chk(16'(tx_act), 16'h0);
	endtask
	task automatic s_frame;
		host_u.send({8'h80, 8'hB0, 8'h81, 8'h22, 8'h82, 8'h33, 8'h83, 8'h44,
			8'h84, 8'h55, 8'h85, 8'h66, 8'h86, 8'h77, 8'h47, 8'h99});
		wait_on(tx_act);
		chk(16'(tx_len), 16'h8);
		raddr <= 6'h1;
		repeat (2) @(posedge clk);
		chk(16'(rdata), 16'h22);
		done <= 1'b1;
		ok <= 1'b1;
		@(posedge clk);
		done <= 1'b0;
		expect_byte(8'h8B);
		host_u.send({8'h80, 8'hB0, 8'h47, 8'h99});
		expect_byte(8'h0B);
		chk(16'(tx_act), 16'h0);
	endtask
	task automatic s_busy;
		host_u.send({8'h03});
		chk(16'(busy), 16'h0);
		host_u.send({8'hF1, 8'h12, 8'h34, 8'h00});
		expect_byte(8'h21);
		chk(paddr, 16'h1234);
		host_u.send({8'h03});
		chk(16'(busy), 16'h1);
		hit <= 1'b1;
		@(posedge clk);
		hit <= 1'b0;
		@(negedge clk);
		chk(16'(ack_busy), 16'h1);
		@(posedge clk);
		host_u.send({8'h11});
		chk(16'(busy), 16'h0);
	endtask
	task automatic s_bus;
		slow <= 1'b1;
		bus_byte(BHS_RX_DATA, 8'hA5);
		expect_byte(8'hA5);
		bus_byte(BHS_RX_CTRL, 8'hFF);
		expect_byte(8'hBC);
		bus_byte(BHS_RX_ACK, 8'hFF);
		host_u.send({8'h05});
		chk(16'(host_u.got_q.size()), 16'h0);
		bus_byte(BHS_RX_ACK, 8'hFF);
		expect_byte(8'hCC);
		host_u.send({8'h02, 8'h01});
		chk(16'(mon), 16'h0);
		chk(16'(aa), 16'h0);
		expect_byte(8'h03);
		slow <= 1'b0;
	endtask
	task automatic s_proto;
		dig <= BHS_D_STOP;
		host_u.send({8'h11});
		expect_byte(8'h17);
		dig <= BHS_D_NORMAL;
		expect_byte(8'h03);
	endtask
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	initial begin
		rst = 1'b1;
		req = '0;
		brx_v = 1'b0;
		brx_k = BHS_RX_DATA;
		brx_d = 8'h00;
		raddr = 6'h0;
		done = 1'b0;
		ok = 1'b0;
		hit = 1'b0;
		err_sc = 1'b0;
		therm = 1'b0;
		dig = BHS_D_NORMAL;
		slow = 1'b0;
		num_errors = 0;
		check_count = 0;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		expect_byte(8'h03);
		s_apb();
		s_state();
		s_frame();
		s_busy();
		s_bus();
		s_proto();
		summarize();
	end
endmodule
